//--- mpp_prog_port.sv
// memory programming port: parallel and serial access to flash, eeprom, fuses and lock bits
// assumes i_clock at 25 MHz; all pins are asynchronous; i_sck comes from the programmer
`timescale 1ns/1ps
`include "mpp_cfg.svh"

module mpp_prog_port #(
   parameter int FLASH_WORDS = 8192,
   parameter int PAGE_WORDS = 64,
   parameter int EEPROM_BYTES = 512,
   parameter int WAIT_FUSE_CYC = `MPP_US_TO_CYC(`MPP_WAIT_FUSE_US),
   parameter int WAIT_FLASH_CYC = `MPP_US_TO_CYC(`MPP_WAIT_FLASH_US),
   parameter int WAIT_EEPROM_CYC = `MPP_US_TO_CYC(`MPP_WAIT_EEPROM_US),
   parameter int WAIT_ERASE_CYC = `MPP_US_TO_CYC(`MPP_WAIT_ERASE_US),
   parameter logic [7:0] SIG_BYTE0 = 8'h5a, // arbitrary value
   parameter logic [7:0] SIG_BYTE1 = 8'h01, // arbitrary value
   parameter logic [7:0] SIG_BYTE2 = 8'h02, // arbitrary value
   parameter logic [7:0] CALIB_BYTE = 8'h80
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_programming_clock_pin,
   input wire logic i_action_select_hi,
   input wire logic i_action_select_lo,
   input wire logic i_byte_select_one,
   input wire logic i_byte_select_two,
   input wire logic i_oe_n,
   input wire logic i_wr_n,
   input wire logic [7:0] i_data,
   input wire logic i_hv_mode,
   input wire logic i_dev_reset_n,
   input wire logic i_sck,
   input wire logic i_mosi,
   output logic [7:0] o_data,
   output logic o_data_oe,
   output logic o_ready_busy_line,
   output logic o_miso
);
   localparam int FA = $clog2(FLASH_WORDS);
   localparam int PA = $clog2(PAGE_WORDS);
   localparam int EA = $clog2(EEPROM_BYTES);

   // ==========================================================================
   // storage
   logic [15:0] flash_mem [FLASH_WORDS];
   logic [7:0] eep_mem [EEPROM_BYTES];
   logic [7:0] buf_lo [PAGE_WORDS];
   logic [7:0] buf_hi [PAGE_WORDS];

   logic [18:0] meta_reg, sync_reg, prev_reg;
   logic [7:0] cmd_reg, dlo_reg, dhi_reg, fuse_lo_reg, fuse_hi_reg, lock_reg;
   logic [15:0] addr_reg;
   logic pe_reg;
   mpp_pkg::mpp_op_t op_reg;
   logic [17:0] cnt_reg;
   logic [13:0] idx_reg;
   logic [FA-1:0] wa_reg;
   logic [7:0] wd_reg, resp_reg;
   logic [23:0] hdr;
   logic [31:0] word;
   logic hdr_tgl, word_tgl;

   // ==========================================================================
   // functions
   function automatic logic [7:0] byte_of(input logic [15:0] w, input logic hi);
      byte_of = hi ? w[15:8] : w[7:0];
   endfunction : byte_of

   function automatic logic [7:0] sig_of(input logic [7:0] a);
      case (a)
         8'h00: sig_of = SIG_BYTE0;
         8'h01: sig_of = SIG_BYTE1;
         8'h02: sig_of = SIG_BYTE2;
         default: sig_of = `MPP_ERASED;
      endcase
   endfunction : sig_of

   // ==========================================================================
   // serial link, held in reset while the device reset pin is released
   wire lnk_arst_n = i_reset_n & ~i_dev_reset_n;

   mpp_spi_link u_link (
      .i_sck(i_sck),
      .i_arst_n(lnk_arst_n),
      .i_mosi(i_mosi),
      .i_resp(resp_reg),
      .o_miso(o_miso),
      .o_hdr(hdr),
      .o_hdr_tgl(hdr_tgl),
      .o_word(word),
      .o_word_tgl(word_tgl)
   );

   // ==========================================================================
   // pin and toggle synchronisers; edges compare the second stage with the third, never the first
   wire [18:0] pin_raw = {hdr_tgl, word_tgl, i_dev_reset_n, i_hv_mode, i_data, i_wr_n,
      i_oe_n, i_byte_select_two, i_byte_select_one, i_action_select_lo,
      i_action_select_hi, i_programming_clock_pin};

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_reg <= `MPP_PIN_IDLE;
         sync_reg <= `MPP_PIN_IDLE;
         prev_reg <= `MPP_PIN_IDLE;
      end else begin
         meta_reg <= pin_raw;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // decoded pins
   wire pclk_rise = sync_reg[0] & ~prev_reg[0];
   wire [1:0] act = {sync_reg[1], sync_reg[2]};
   wire bs1 = sync_reg[3];
   wire bs2 = sync_reg[4];
   wire oe_n = sync_reg[5];
   wire wr_fall = ~sync_reg[6] & prev_reg[6];
   wire [7:0] pdata = sync_reg[14:7];
   wire par_mode = sync_reg[15];
   wire ser_mode = ~sync_reg[16] & ~sync_reg[15];
   wire word_evt = sync_reg[17] ^ prev_reg[17];
   wire hdr_evt = sync_reg[18] ^ prev_reg[18];
   wire idle = (op_reg == mpp_pkg::OP_NONE);

   // serial instruction fields; held words stay put until the next toggle
   wire [7:0] b1 = word[31:24];
   wire [7:0] b2 = word[23:16];
   wire [7:0] b4 = word[7:0];
   wire [FA-1:0] s_faddr = word[FA+7:8];
   wire [EA-1:0] s_eaddr = word[EA+7:8];
   wire [FA-1:0] h_faddr = hdr[FA-1:0];
   wire [EA-1:0] h_eaddr = hdr[EA-1:0];
   wire s_pe = (b1 == `MPP_SER_AC) & (b2 == `MPP_SER_PE);
   wire ser_ok = ser_mode & word_evt & pe_reg & idle;
   wire s_ac = ser_ok & (b1 == `MPP_SER_AC);

   // ==========================================================================
   // operation starts, either port
   wire par_go = par_mode & wr_fall & idle;
   wire go_erase = (par_go & (cmd_reg == `MPP_CMD_ERASE)) | (s_ac & (b2 == `MPP_SER_ERASE));
   wire go_lock = (par_go & (cmd_reg == `MPP_CMD_WR_LOCK))
      | (s_ac & (b2 == `MPP_SER_WR_LOCK));
   wire go_fuse_lo = (par_go & (cmd_reg == `MPP_CMD_WR_FUSE) & ~bs1 & ~bs2)
      | (s_ac & (b2 == `MPP_SER_WR_FUSE));
   wire go_fuse_hi = (par_go & (cmd_reg == `MPP_CMD_WR_FUSE) & bs1 & ~bs2)
      | (s_ac & (b2 == `MPP_SER_WR_FUSE_HI));
   wire go_eep = (par_go & (cmd_reg == `MPP_CMD_WR_EEPROM))
      | (ser_ok & (b1 == `MPP_SER_WR_EEP));
   wire go_page = ser_ok & (b1 == `MPP_SER_WR_PAGE);
   wire go_wait = go_lock | go_fuse_lo | go_fuse_hi;
   wire go_any = go_erase | go_eep | go_page | go_wait;
   wire [7:0] st_data = par_mode ? dlo_reg : b4;
   wire [EA-1:0] st_eaddr = par_mode ? addr_reg[EA-1:0] : s_eaddr;
   wire last_cyc = ~idle & (cnt_reg == 18'h00001);
   wire [FA-1:0] pg_dst = {wa_reg[FA-1:PA], idx_reg[PA-1:0]};

   // ==========================================================================
   // parallel load of command, address and data bytes
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cmd_reg <= 8'h00;
         addr_reg <= 16'h0000;
         dlo_reg <= 8'h00;
         dhi_reg <= 8'h00;
      end else if (par_mode & pclk_rise & idle) begin
         case (act)
            `MPP_ACT_CMD: cmd_reg <= pdata;
            `MPP_ACT_ADDR: begin
               if (bs1) addr_reg[15:8] <= pdata;
               else addr_reg[7:0] <= pdata;
            end
            `MPP_ACT_DATA: begin
               if (bs1) dhi_reg <= pdata;
               else dlo_reg <= pdata;
            end
            default: ;
         endcase
      end
   end

   // ==========================================================================
   // programming enable: cleared whenever the device reset pin is released
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) pe_reg <= 1'b0;
      else if (!ser_mode) pe_reg <= 1'b0;
      else if (word_evt & s_pe) pe_reg <= 1'b1;
   end

   // ==========================================================================
   // self-timed operation sequencer
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         op_reg <= mpp_pkg::OP_NONE;
         cnt_reg <= 18'h0;
         idx_reg <= 14'h0;
         wa_reg <= '0;
         wd_reg <= 8'h00;
      end else begin
         case (op_reg)
            mpp_pkg::OP_NONE: begin
               idx_reg <= 14'h0;
               if (go_erase) begin
                  op_reg <= mpp_pkg::OP_ERASE;
                  cnt_reg <= 18'(WAIT_ERASE_CYC);
               end else if (go_page) begin
                  op_reg <= mpp_pkg::OP_PAGE;
                  cnt_reg <= 18'(WAIT_FLASH_CYC);
                  wa_reg <= s_faddr;
               end else if (go_eep) begin
                  op_reg <= mpp_pkg::OP_EEPROM;
                  cnt_reg <= 18'(WAIT_EEPROM_CYC);
                  wa_reg <= FA'(st_eaddr);
                  wd_reg <= st_data;
               end else if (go_wait) begin
                  op_reg <= mpp_pkg::OP_WAIT;
                  cnt_reg <= 18'(WAIT_FUSE_CYC);
               end
            end
            default: begin
               cnt_reg <= cnt_reg - 18'h1;
               if (idx_reg < 14'(FLASH_WORDS)) idx_reg <= idx_reg + 14'h1;
               if (last_cyc) op_reg <= mpp_pkg::OP_NONE;
            end
         endcase
      end
   end

   // ==========================================================================
   // fuse and lock bits; a write can only clear lock bits, erase restores them
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fuse_lo_reg <= `MPP_FUSE_LO_RST;
         fuse_hi_reg <= `MPP_FUSE_HI_RST;
         lock_reg <= `MPP_LOCK_RST;
      end else begin
         if (go_fuse_lo) fuse_lo_reg <= st_data;
         if (go_fuse_hi) fuse_hi_reg <= st_data;
         if (go_lock) lock_reg <= lock_reg & st_data;
         else if (last_cyc & (op_reg == mpp_pkg::OP_ERASE)) lock_reg <= `MPP_LOCK_RST;
      end
   end

   // ==========================================================================
   // memory arrays; no reset, the content is nonvolatile
   always_ff @(posedge i_clock) begin
      if ((op_reg == mpp_pkg::OP_ERASE) && (idx_reg < 14'(FLASH_WORDS)))
         flash_mem[idx_reg[FA-1:0]] <= {`MPP_ERASED, `MPP_ERASED};
      else if ((op_reg == mpp_pkg::OP_PAGE) && (idx_reg < 14'(PAGE_WORDS)))
         flash_mem[pg_dst] <= {buf_hi[idx_reg[PA-1:0]], buf_lo[idx_reg[PA-1:0]]};
      if ((op_reg == mpp_pkg::OP_ERASE) && (idx_reg < 14'(EEPROM_BYTES)))
         eep_mem[idx_reg[EA-1:0]] <= `MPP_ERASED;
      else if (last_cyc && (op_reg == mpp_pkg::OP_EEPROM))
         eep_mem[wa_reg[EA-1:0]] <= wd_reg;
      if (ser_ok & (b1 == `MPP_SER_LD_LO)) buf_lo[s_faddr[PA-1:0]] <= b4;
      if (ser_ok & (b1 == `MPP_SER_LD_HI)) buf_hi[s_faddr[PA-1:0]] <= b4;
   end

   // ==========================================================================
   // serial read answer; busy locations read erased until the write completes
   wire page_hit = (op_reg == mpp_pkg::OP_PAGE) && (h_faddr[FA-1:PA] == wa_reg[FA-1:PA]);
   wire eep_hit = (op_reg == mpp_pkg::OP_EEPROM) && (h_eaddr == wa_reg[EA-1:0]);
   logic [7:0] resp_next;

   always_comb begin
      case (hdr[23:16])
         `MPP_SER_RD_LO, `MPP_SER_RD_HI: resp_next = page_hit ? `MPP_ERASED
            : byte_of(flash_mem[h_faddr], hdr[19]);
         `MPP_SER_RD_EEP: resp_next = eep_hit ? `MPP_ERASED : eep_mem[h_eaddr];
         `MPP_SER_RD_LOCK: resp_next = (hdr[15:8] == `MPP_SER_HI_SEL) ? fuse_hi_reg : lock_reg;
         `MPP_SER_RD_FUSE: resp_next = (hdr[15:8] == `MPP_SER_HI_SEL) ? `MPP_ERASED : fuse_lo_reg;
         `MPP_SER_RD_SIG: resp_next = sig_of({6'h00, hdr[1:0]});
         `MPP_SER_RD_CAL: resp_next = CALIB_BYTE;
         `MPP_SER_POLL: resp_next = {7'h00, ~idle};
         default: resp_next = 8'h00;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) resp_reg <= 8'h00;
      else if (hdr_evt) resp_reg <= resp_next;
   end

   // ==========================================================================
   // parallel read selection
   wire [7:0] fuse_sel = ({bs2, bs1} == 2'b00) ? fuse_lo_reg
      : ({bs2, bs1} == 2'b11) ? fuse_hi_reg
      : ({bs2, bs1} == 2'b01) ? lock_reg : `MPP_ERASED;
   wire [7:0] sig_sel = bs1 ? ((addr_reg[7:0] == 8'h00) ? CALIB_BYTE : `MPP_ERASED)
      : sig_of(addr_reg[7:0]);
   wire [7:0] par_rd = (cmd_reg == `MPP_CMD_RD_EEPROM) ? eep_mem[addr_reg[EA-1:0]]
      : (cmd_reg == `MPP_CMD_RD_FUSE) ? fuse_sel
      : (cmd_reg == `MPP_CMD_RD_SIG) ? sig_sel
      : (cmd_reg == `MPP_CMD_RD_FLASH) ? byte_of(flash_mem[addr_reg[FA-1:0]], bs1)
      : `MPP_ERASED;

   // ==========================================================================
   // pin outputs, all registered
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_data <= 8'h00;
         o_data_oe <= 1'b0;
         o_ready_busy_line <= 1'b1;
      end else begin
         o_data <= par_rd;
         o_data_oe <= par_mode & ~oe_n;
         o_ready_busy_line <= ~(go_any | (~idle & ~last_cyc));
      end
   end

   // ==========================================================================
   // checks
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_reset_n);

   property p_oe_release;
      oe_n |=> !o_data_oe;
   endproperty
   a_oe_release: assert property (p_oe_release) else $error("data driven with oe high");

   property p_busy_start;
      go_any |=> !o_ready_busy_line [*2];
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("ready not low after start");

   property p_lock_sticky;
      !$past(last_cyc && op_reg == mpp_pkg::OP_ERASE) |-> ((lock_reg & ~$past(lock_reg)) == 8'h00);
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit unprogrammed");

   property p_no_enable;
      (word_evt && !pe_reg && idle) |=> (op_reg == mpp_pkg::OP_NONE);
   endproperty
   a_no_enable: assert property (p_no_enable) else $error("write taken before enable");

   property p_leave;
      (!ser_mode) |=> !pe_reg;
   endproperty
   a_leave: assert property (p_leave) else $error("enable kept after reset release");

   property p_page_busy;
      (hdr_evt && page_hit && hdr[23:16] == `MPP_SER_RD_LO) |=> (resp_reg == `MPP_ERASED);
   endproperty
   a_page_busy: assert property (p_page_busy) else $error("busy page not read as ones");

   property p_eep_read;
      (cmd_reg == `MPP_CMD_RD_EEPROM && par_mode && !oe_n && idle)
         |=> (o_data == $past(eep_mem[addr_reg[EA-1:0]]) && o_data_oe);
   endproperty
   a_eep_read: assert property (p_eep_read) else $error("eeprom byte not presented");

   property p_lock_read;
      (cmd_reg == `MPP_CMD_RD_FUSE && !bs2 && bs1) |=> (o_data == $past(lock_reg));
   endproperty
   a_lock_read: assert property (p_lock_read) else $error("lock bits not presented");

   property p_eep_done;
      (last_cyc && op_reg == mpp_pkg::OP_EEPROM) |=> (eep_mem[$past(wa_reg[EA-1:0])] == $past(wd_reg));
   endproperty
   a_eep_done: assert property (p_eep_done) else $error("eeprom byte not written");
endmodule : mpp_prog_port

//--- mpp_cfg.svh
// constants for the memory programming port: command codes, pin codes, reset values, timing
// assumes a 25 MHz system clock; included by the programming port files and its bench
`ifndef MPP_CFG_SVH
`define MPP_CFG_SVH

// ==========================================================================
// parallel command bytes
`define MPP_CMD_ERASE 8'h80
`define MPP_CMD_WR_FUSE 8'h40
`define MPP_CMD_WR_LOCK 8'h20
`define MPP_CMD_WR_EEPROM 8'h11
`define MPP_CMD_RD_SIG 8'h08
`define MPP_CMD_RD_FUSE 8'h04
`define MPP_CMD_RD_FLASH 8'h02
`define MPP_CMD_RD_EEPROM 8'h03

// ==========================================================================
// action select codes {hi, lo}
`define MPP_ACT_ADDR 2'b00
`define MPP_ACT_DATA 2'b01
`define MPP_ACT_CMD 2'b10

// ==========================================================================
// serial instruction bytes
`define MPP_SER_AC 8'hac
`define MPP_SER_PE 8'h53
`define MPP_SER_ERASE 8'h80
`define MPP_SER_WR_LOCK 8'he0
`define MPP_SER_WR_FUSE 8'ha0
`define MPP_SER_WR_FUSE_HI 8'ha8
`define MPP_SER_POLL 8'hf0
`define MPP_SER_LD_LO 8'h40
`define MPP_SER_LD_HI 8'h48
`define MPP_SER_WR_PAGE 8'h4c
`define MPP_SER_RD_LO 8'h20
`define MPP_SER_RD_HI 8'h28
`define MPP_SER_RD_EEP 8'ha0
`define MPP_SER_WR_EEP 8'hc0
`define MPP_SER_RD_LOCK 8'h58
`define MPP_SER_RD_FUSE 8'h50
`define MPP_SER_RD_SIG 8'h30
`define MPP_SER_RD_CAL 8'h38
`define MPP_SER_HI_SEL 8'h08

// ==========================================================================
// serial bit counts (msb first, 32 bits per instruction)
`define MPP_HDR_LAST 5'h17
`define MPP_WORD_LAST 5'h1f
`define MPP_RESP_START 5'h18

// ==========================================================================
// reset values: unprogrammed bits read as one
`define MPP_FUSE_LO_RST 8'hff
`define MPP_FUSE_HI_RST 8'hff
`define MPP_LOCK_RST 8'hff
`define MPP_ERASED 8'hff
`define MPP_PIN_IDLE 19'h10060

// ==========================================================================
// timing
`define MPP_CLK_KHZ 25000
`define MPP_WAIT_FUSE_US 4500
`define MPP_WAIT_FLASH_US 4500
`define MPP_WAIT_EEPROM_US 9000
`define MPP_WAIT_ERASE_US 9000
`define MPP_US_TO_CYC(us) (((us) * `MPP_CLK_KHZ) / 1000)

`endif

//--- mpp_pkg.sv
// types shared by the memory programming port
// assumes nothing beyond a SystemVerilog compiler
package mpp_pkg;
   // ==========================================================================
   // self-timed operation in progress
   typedef enum logic [2:0] {
      OP_NONE,
      OP_ERASE,
      OP_PAGE,
      OP_EEPROM,
      OP_WAIT
   } mpp_op_t;
endpackage : mpp_pkg

//--- mpp_spi_link.sv
// serial link end of the programming port, clocked by the programmer's sck
// assumes i_arst_n is low whenever serial programming is not active
`timescale 1ns/1ps
`include "mpp_cfg.svh"

module mpp_spi_link (
   input wire logic i_sck,
   input wire logic i_arst_n,
   input wire logic i_mosi,
   input wire logic [7:0] i_resp,
   output logic o_miso,
   output logic [23:0] o_hdr,
   output logic o_hdr_tgl,
   output logic [31:0] o_word,
   output logic o_word_tgl
);
   logic [30:0] in_sr_reg;
   logic [4:0] cnt_reg;
   logic [7:0] out_sr_reg;
   wire [31:0] in_next = {in_sr_reg, i_mosi};
   wire byte_edge = (cnt_reg[2:0] == 3'h0);

   // ==========================================================================
   // input shifting on rising sck; held words only change at their own count
   always_ff @(posedge i_sck or negedge i_arst_n) begin
      if (!i_arst_n) begin
         in_sr_reg <= 31'h0;
         cnt_reg <= 5'h00;
         o_hdr <= 24'h0;
         o_hdr_tgl <= 1'b0;
         o_word <= 32'h0;
         o_word_tgl <= 1'b0;
      end else begin
         in_sr_reg <= in_next[30:0];
         cnt_reg <= cnt_reg + 5'h01;
         if (cnt_reg == `MPP_HDR_LAST) begin
            o_hdr <= in_next[23:0];
            o_hdr_tgl <= ~o_hdr_tgl;
         end
         if (cnt_reg == `MPP_WORD_LAST) begin
            o_word <= in_next;
            o_word_tgl <= ~o_word_tgl;
         end
      end
   end

   // ==========================================================================
   // output shifting on falling sck; bytes echo the previous one, except the fourth, which carries the read answer
   // limitation: the read byte must be settled before the falling edge after bit 24
   always_ff @(negedge i_sck or negedge i_arst_n) begin
      if (!i_arst_n) begin
         out_sr_reg <= 8'h00;
      end else if (byte_edge) begin
         if (cnt_reg == `MPP_RESP_START) begin
            out_sr_reg <= i_resp;
         end else begin
            out_sr_reg <= in_sr_reg[7:0];
         end
      end else begin
         out_sr_reg <= {out_sr_reg[6:0], 1'b0};
      end
   end

   assign o_miso = out_sr_reg[7];
endmodule : mpp_spi_link

//--- mpp_spi_prog_model.sv
// serial programmer model: 32 sck periods per instruction, msb first
// assumes the port samples on rising sck and shifts out on falling sck
`timescale 1ns/1ps
module mpp_spi_prog_model (
   output logic o_sck,
   output logic o_mosi,
   input wire logic i_miso
);
   // ==========================================================================
   // idle levels: sck stands low outside frames
   initial begin
      o_sck = 1'b0;
      o_mosi = 1'b0;
   end
   // one instruction; bit set while sck low, answer taken at rising sck
   // limitation: 32 ns phases are faster than the cpu clock, so only echo is usable
   task automatic xfer(input logic [31:0] w, output logic [31:0] r);
      for (int i = 31; i >= 0; i--) begin
         o_mosi = w[i];
         #32 o_sck = 1'b1;
         r[i] = i_miso;
         #32 o_sck = 1'b0;
      end
      o_mosi = ~o_mosi; // line left at the inverse of the last bit sent
   endtask : xfer
endmodule : mpp_spi_prog_model

//--- mpp_prog_port_tb_top.sv
// bench for the programming port: fuse, lock, id reads and serial enable echo
// assumes the serial programmer model beside it
`timescale 1ns/1ps
`include "mpp_cfg.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
   $display("[ERR] %s exp %h got %h", n, e, a); end end
module mpp_prog_port_tb_top;
   localparam logic [7:0] SIG2 = 8'h3c; // arbitrary value
   localparam logic [7:0] CAL = 8'h9e;
   logic clk = 1'b0, rst_n = 1'b0, pclk = 1'b0, ahi = 1'b1, alo = 1'b1, bs1 = 1'b0;
   logic bs2 = 1'b0, oe_n = 1'b1, wr_n = 1'b1, hv = 1'b1, dev_rst_n = 1'b1;
   logic [7:0] din = 8'h00, dout, fuse, lock;
   logic doe, rdy, sck, mosi, miso;
   logic [31:0] rx;
   int err_count = 0, samples_checked = 0, seed = 32'h5a0b;
   // ==========================================================================
   // clock, design and serial programmer
   initial forever #20 clk = ~clk;
   // page size and flash wait keep their defaults; no page write runs here
   mpp_prog_port #(.FLASH_WORDS(256), .EEPROM_BYTES(64),
      .WAIT_FUSE_CYC(100), .WAIT_EEPROM_CYC(100),
      .WAIT_ERASE_CYC(300), .SIG_BYTE2(SIG2), .CALIB_BYTE(CAL)) i_mpp_prog_port (
      .i_clock(clk), .i_reset_n(rst_n), .i_programming_clock_pin(pclk),
      .i_action_select_hi(ahi), .i_action_select_lo(alo), .i_byte_select_one(bs1),
      .i_byte_select_two(bs2), .i_oe_n(oe_n), .i_wr_n(wr_n), .i_data(din),
      .i_hv_mode(hv), .i_dev_reset_n(dev_rst_n), .i_sck(sck), .i_mosi(mosi),
      .o_data(dout), .o_data_oe(doe), .o_ready_busy_line(rdy), .o_miso(miso));
   mpp_spi_prog_model i_prog (.o_sck(sck), .o_mosi(mosi), .i_miso(miso));
   // ==========================================================================
   // pin tasks; pins are synchronised, so every level is held several clocks
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic load(input logic [1:0] act, input logic sel, input logic [7:0] d);
      {ahi, alo} <= act;
      bs1 <= sel;
      din <= d;
      cyc(4);
      pclk <= 1'b1;
      cyc(6);
      pclk <= 1'b0;
      cyc(6);
   endtask : load
   task automatic strobe(input logic [7:0] cmd, input logic [7:0] d, input logic s1);
      load(`MPP_ACT_CMD, 1'b0, cmd);
      load(`MPP_ACT_DATA, 1'b0, d);
      bs1 <= s1;
      bs2 <= 1'b0;
      cyc(2);
      wr_n <= 1'b0;
      cyc(6);
      @(negedge clk);
      `CHK("busy", 1'b0, rdy)
      for (int i = 0; i < 400 && rdy !== 1'b1; i++) @(negedge clk);
      `CHK("ready", 1'b1, rdy)
      cyc(1);
      wr_n <= 1'b1;
      bs1 <= 1'b0;
      cyc(4);
   endtask : strobe
   task automatic rd(input logic s2, input logic s1, input logic [7:0] e, input string n);
      bs2 <= s2;
      bs1 <= s1;
      oe_n <= 1'b0;
      cyc(6);
      @(negedge clk);
      `CHK(n, e, dout)
      `CHK("drive", 1'b1, doe)
      cyc(1);
      oe_n <= 1'b1;
      cyc(6);
      @(negedge clk);
      `CHK("release", 1'b0, doe)
      cyc(1);
   endtask : rd
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run
   // watchdog: the whole run needs well under 10000 clocks
   initial begin
      #400000;
      err_count++;
      complete_run();
   end
   // ==========================================================================
   // main sequence
   initial begin
      cyc(8);
      rst_n <= 1'b1;
      fuse = $random(seed);
      lock = $random(seed);
      cyc(2);
      strobe(`MPP_CMD_WR_FUSE, fuse, 1'b0);
      strobe(`MPP_CMD_WR_FUSE, ~fuse, 1'b1);
      load(`MPP_ACT_CMD, 1'b0, `MPP_CMD_RD_FUSE);
      rd(1'b0, 1'b0, fuse, "fuse low");
      rd(1'b1, 1'b1, ~fuse, "fuse high");
      // ones written over programmed lock bits must not set them back to one
      strobe(`MPP_CMD_WR_LOCK, lock, 1'b0);
      strobe(`MPP_CMD_WR_LOCK, 8'hff, 1'b0);
      load(`MPP_ACT_CMD, 1'b0, `MPP_CMD_RD_FUSE);
      rd(1'b0, 1'b1, lock, "lock");
      $display("fuse and lock test done");
      load(`MPP_ACT_CMD, 1'b0, `MPP_CMD_RD_SIG);
      load(`MPP_ACT_ADDR, 1'b0, 8'h02);
      rd(1'b0, 1'b0, SIG2, "signature");
      load(`MPP_ACT_ADDR, 1'b0, 8'h00);
      rd(1'b0, 1'b1, CAL, "calibration");
      $display("id read test done");
      hv <= 1'b0;
      dev_rst_n <= 1'b0;
      // scaled settle time before enable; sck already stands low from the model
      cyc(4);
      // one instruction, then its echo is checked and the run ends
      i_prog.xfer({`MPP_SER_AC, `MPP_SER_PE, 16'h0000}, rx);
      `CHK("echo", `MPP_SER_PE, rx[15:8])
      $display("serial enable test done");
      complete_run();
   end
endmodule : mpp_prog_port_tb_top
